// File: pkg/itw_pkg.sv
// Package: register map, fields and timing of the interval timer and watchdog
package itw_pkg;

    // ****************************************
    // Register indices (byte address = 4 x index)
    // ****************************************
    localparam logic [4:0] IDX_STATUS = 5'h04;
    localparam logic [4:0] IDX_IRQ_FLAG = 5'h06;
    localparam logic [4:0] IDX_IRQ_EN = 5'h07;
    localparam logic [4:0] IDX_WDT_CTRL = 5'h0D;
    localparam logic [4:0] IDX_TMR_COUNT = 5'h0E;
    localparam logic [4:0] IDX_TMR_CTRL = 5'h0F;
    localparam logic [4:0] IDX_CLK_SEL = 5'h14;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int WDT_FLAG_BIT = 3;
    localparam int TMR_FLAG_BIT = 4;
    localparam int TMR_IE_BIT = 4;
    localparam int GIE_BIT = 7;
    localparam int WDT_RUN_BIT = 7;
    localparam int TRST_BIT = 7;
    localparam int TMR_RUN_BIT = 3;
    localparam int TSRC_BIT = 5;
    localparam int EXT_HALVE_BIT = 3;
    localparam int CORE_DIV_BIT = 1;
    localparam int MAIN_SRC_BIT = 0;

    // ****************************************
    // Reset values and vectors
    // ****************************************
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] IRQ_VECTOR = 8'h04;
    localparam logic [7:0] RESET_VECTOR = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int ICK_HZ = 1_000_000;
    localparam int ICK_DIV = CLK_HZ / ICK_HZ;
    localparam int WDT_OSC_HZ = 3_000;
    localparam int WDT_OSC_DIV = CLK_HZ / WDT_OSC_HZ;
    localparam int TMR_PRESCALE = 4;
    localparam int TMR_CORE_DIV = 1000;
    localparam int TMR_EXT_DIV = 32;
    localparam int CORE_DIV = 4;

endpackage

// File: hw/itw_clk_gen.sv
// Clock-enable tree: main, core and timer source rates
`timescale 1ns/1ns
`default_nettype none
module itw_clk_gen
    import itw_pkg::*;
#(
    parameter int ICK_DIV_P = ICK_DIV,
    parameter int CORE_DIV_P = CORE_DIV,
    parameter int TCORE_DIV_P = TMR_CORE_DIV,
    parameter int TEXT_DIV_P = TMR_EXT_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Crystal pin
    input wire logic ext_crystal_clk,
    // Selects
    input wire logic main_clk_src_sel,
    input wire logic ext_clk_halve_sel,
    input wire logic core_clk_div_sel,
    input wire logic timer_clk_src_sel,
    // Timer source rate
    output logic timer_src_en
);
    if (ICK_DIV_P < 2 || CORE_DIV_P < 2 || TCORE_DIV_P < 2 || TEXT_DIV_P < 2 ||
        TCORE_DIV_P > 65536 || ICK_DIV_P > 65536) begin : g_bad
        $error("itw_clk_gen: divider out of range");
    end

    logic ext_meta, ext_sync, ext_prev, half_t;
    logic [15:0] ick_cnt, core_cnt, tcore_cnt, text_cnt;
    logic ext_rise, ick_en, main_en, core_en;

    // Crystal edge becomes a one-cycle enable; meta stage read only by sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ext_crystal_clk;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end
    assign ext_rise = ext_sync & ~ext_prev;

    // Rate selection, each a pulse in the system clock
    assign ick_en = (ick_cnt == 16'(ICK_DIV_P - 1));
    assign main_en = !main_clk_src_sel ? ick_en :
                     (ext_clk_halve_sel ? (ext_rise & half_t) : ext_rise);
    assign core_en = core_clk_div_sel ?
                     (main_en && core_cnt == 16'(CORE_DIV_P - 1)) : main_en;
    assign timer_src_en = timer_clk_src_sel ?
                          (ext_rise && text_cnt == 16'(TEXT_DIV_P - 1)) :
                          (core_en && tcore_cnt == 16'(TCORE_DIV_P - 1));

    // Free-running dividers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ick_cnt <= 16'h0000;
            core_cnt <= 16'h0000;
            tcore_cnt <= 16'h0000;
            text_cnt <= 16'h0000;
            half_t <= 1'b0;
        end else begin
            ick_cnt <= ick_en ? 16'h0000 : ick_cnt + 16'h0001;
            if (ext_rise) begin
                half_t <= ~half_t;
                text_cnt <= (text_cnt == 16'(TEXT_DIV_P - 1)) ? 16'h0000 : text_cnt + 16'h0001;
            end
            if (main_en) begin
                core_cnt <= (core_cnt == 16'(CORE_DIV_P - 1)) ? 16'h0000 : core_cnt + 16'h0001;
            end
            if (core_en) begin
                tcore_cnt <= (tcore_cnt == 16'(TCORE_DIV_P - 1)) ? 16'h0000 :
                             tcore_cnt + 16'h0001;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    src_pulse_a: assert property (timer_src_en |=> !timer_src_en)
        else $error("timer source enable longer than one cycle");
endmodule
`default_nettype wire

// File: hw/itw_wdt.sv
// Watchdog: own oscillator, two cascaded 8-bit counters, expiry pulse
`timescale 1ns/1ns
`default_nettype none
module itw_wdt
    import itw_pkg::*;
#(
    parameter int OSC_DIV_P = WDT_OSC_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic watchdog_run,
    input wire logic [2:0] watchdog_tap_select,
    input wire logic watchdog_clear,
    // Expiry
    output logic watchdog_expire
);
    if (OSC_DIV_P < 2) begin : g_bad
        $error("itw_wdt: oscillator divider too small");
    end

    // Reverse mapping: code 7 picks bit 0, code 0 picks bit 7
    function automatic logic [2:0] tap_bit(input logic [2:0] code);
        tap_bit = 3'h7 - code;
    endfunction

    logic [31:0] osc_cnt;
    logic [7:0] watchdog_prescale_taps, cnt2;
    logic tap_prev, osc_en, tap_now, tap_rise;

    assign osc_en = watchdog_run && osc_cnt == 32'(OSC_DIV_P - 1);
    assign tap_now = watchdog_prescale_taps[tap_bit(watchdog_tap_select)];
    assign tap_rise = tap_now & ~tap_prev;

    // Clear wins over counting so the interval restarts from zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt <= 32'h0000_0000;
            watchdog_prescale_taps <= 8'h00;
            cnt2 <= 8'h00;
            tap_prev <= 1'b0;
            watchdog_expire <= 1'b0;
        end else if (watchdog_clear) begin
            osc_cnt <= 32'h0000_0000;
            watchdog_prescale_taps <= 8'h00;
            cnt2 <= 8'h00;
            tap_prev <= 1'b0;
            watchdog_expire <= 1'b0;
        end else begin
            if (watchdog_run) begin
                osc_cnt <= osc_en ? 32'h0000_0000 : osc_cnt + 32'h0000_0001;
            end
            if (osc_en) begin
                watchdog_prescale_taps <= watchdog_prescale_taps + 8'h01;
            end
            tap_prev <= tap_now;
            if (tap_rise) begin
                cnt2 <= cnt2 + 8'h01;
            end
            watchdog_expire <= tap_rise && cnt2 == 8'hFF;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    wdt_clear_a: assert property (watchdog_clear |=>
        (watchdog_prescale_taps == 8'h00 && cnt2 == 8'h00))
        else $error("watchdog counters not cleared");
    wdt_hold_a: assert property (!watchdog_run && !watchdog_clear |=>
        $stable(watchdog_prescale_taps))
        else $error("watchdog counted while stopped");
    wdt_expire_a: assert property (tap_rise && cnt2 == 8'hFF && !watchdog_clear |=>
        watchdog_expire ##1 (cnt2 == 8'h00 || watchdog_clear))
        else $error("watchdog overflow missed");
endmodule
`default_nettype wire

// File: hw/itw_top.sv
// Interval timer and watchdog with Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none

module itw_top
    import itw_pkg::*;
#(
    parameter int WDT_OSC_DIV_P = WDT_OSC_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,

    // Avalon-MM slave
    input wire logic [6:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,

    // External crystal pin
    input wire logic external_crystal_clock,

    // CPU side
    input wire logic watchdog_clear_instr,
    output logic timer_irq,
    output logic [7:0] irq_vector,
    output logic watchdog_expire,
    output logic [7:0] reset_vector
);

    // ****************************************
    // Reset release
    // ****************************************

    logic rst_meta_n, rst_sync_n;

    // Release is synchronised; assertion stays asynchronous
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ****************************************
    // Declarations
    // ****************************************

    logic ack, req, wr_go;
    logic [4:0] idx;
    logic hit_status, hit_flag, hit_en, hit_wdt, hit_cnt, hit_tmr, hit_clk;
    logic wr_flag, wr_en, wr_wdt, wr_tmr, wr_clk;
    logic [7:0] rd_mux;

    logic [7:0] irq_enable_reg;
    logic [7:0] clock_select;
    logic watchdog_run;
    logic [2:0] watchdog_tap_select;
    logic timer_count_clear_n;
    logic timer_run;
    logic [2:0] timer_tap_select;
    logic timer_irq_flag;
    logic watchdog_expired_flag;

    logic timer_src_en;
    logic [1:0] prescale;
    logic tmr_adv;
    logic [7:0] timer_count_value;
    logic tap_now, tap_prev, tmr_event;

    // ****************************************
    // Bus slave
    // ****************************************

    // Every access waits exactly one cycle, giving read data a register stage
    assign req = read | write;
    assign waitrequest = req & ~ack;
    assign wr_go = write & ack & byteenable[0];
    assign idx = address[6:2];

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    // Address decode
    assign hit_status = (idx == IDX_STATUS);
    assign hit_flag = (idx == IDX_IRQ_FLAG);
    assign hit_en = (idx == IDX_IRQ_EN);
    assign hit_wdt = (idx == IDX_WDT_CTRL);
    assign hit_cnt = (idx == IDX_TMR_COUNT);
    assign hit_tmr = (idx == IDX_TMR_CTRL);
    assign hit_clk = (idx == IDX_CLK_SEL);

    // Write strobes; status and count are not writable
    assign wr_flag = wr_go & hit_flag;
    assign wr_en = wr_go & hit_en;
    assign wr_wdt = wr_go & hit_wdt;
    assign wr_tmr = wr_go & hit_tmr;
    assign wr_clk = wr_go & hit_clk;

    // Read selection; unmapped words and reserved status, flag and control bits read zero; enable and clock select return all 8 written bits
    assign rd_mux =
        hit_status ? (8'h00 | (8'(watchdog_expired_flag) << WDT_FLAG_BIT)) :
        hit_flag ? (8'h00 | (8'(timer_irq_flag) << TMR_FLAG_BIT)) :
        hit_en ? irq_enable_reg :
        hit_wdt ? {watchdog_run, 4'h0, watchdog_tap_select} :
        hit_cnt ? timer_count_value :
        hit_tmr ? {timer_count_clear_n, 3'h0, timer_run, timer_tap_select} :
        hit_clk ? clock_select :
        8'h00;

    // Read data captured during the wait cycle, held through the answer
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack) begin
            readdata <= {24'h00_0000, rd_mux};
        end
    end

    // ****************************************
    // Control registers
    // ****************************************

    // Plain read/write settings
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_enable_reg <= RST_ZERO;
            clock_select <= RST_ZERO;
            watchdog_run <= 1'b0;
            watchdog_tap_select <= 3'h0;
            timer_run <= 1'b0;
            timer_tap_select <= 3'h0;
        end else begin
            if (wr_en) begin
                irq_enable_reg <= writedata[7:0];
            end
            if (wr_clk) begin
                clock_select <= writedata[7:0];
            end
            if (wr_wdt) begin
                watchdog_run <= writedata[WDT_RUN_BIT];
                watchdog_tap_select <= writedata[2:0];
            end
            if (wr_tmr) begin
                timer_run <= writedata[TMR_RUN_BIT];
                timer_tap_select <= writedata[2:0];
            end
        end
    end

    // Clear bit drops for one cycle after a zero is written, then rises again
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_count_clear_n <= 1'b1;
        end else begin
            timer_count_clear_n <= !(wr_tmr && !writedata[TRST_BIT]);
        end
    end

    // ****************************************
    // Clock enables
    // ****************************************

    itw_clk_gen itw_clk_gen_i (
        .clk(clk),
        .rst_n(rst_sync_n),
        .ext_crystal_clk(external_crystal_clock),
        .main_clk_src_sel(clock_select[MAIN_SRC_BIT]),
        .ext_clk_halve_sel(clock_select[EXT_HALVE_BIT]),
        .core_clk_div_sel(clock_select[CORE_DIV_BIT]),
        .timer_clk_src_sel(clock_select[TSRC_BIT]),
        .timer_src_en(timer_src_en)
    );

    // ****************************************
    // Interval timer
    // ****************************************

    // Prescaler wrap gates the counter; clear restarts both
    assign tmr_adv = timer_count_clear_n && timer_run && timer_src_en &&
                     prescale == 2'(TMR_PRESCALE - 1);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prescale <= 2'h0;
            timer_count_value <= RST_ZERO;
        end else if (!timer_count_clear_n) begin
            prescale <= 2'h0;
            timer_count_value <= RST_ZERO;
        end else begin
            if (timer_run && timer_src_en) begin
                prescale <= prescale + 2'h1;
            end
            if (tmr_adv) begin
                timer_count_value <= timer_count_value + 8'h01;
            end
        end
    end

    // Period is twice the toggle time of the chosen bit
    assign tap_now = timer_count_value[timer_tap_select];
    assign tmr_event = tap_now & ~tap_prev;

    // Edge history; a tap change may itself look like an edge
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tap_prev <= 1'b0;
        end else begin
            tap_prev <= tap_now;
        end
    end

    // Flag: a new event beats a software clear in the same cycle
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_irq_flag <= 1'b0;
        end else if (tmr_event) begin
            timer_irq_flag <= 1'b1;
        end else if (wr_flag && !writedata[TMR_FLAG_BIT]) begin
            timer_irq_flag <= 1'b0;
        end
    end

    // Interrupt to the core and its vector
    assign timer_irq = timer_irq_flag && irq_enable_reg[TMR_IE_BIT] &&
                       irq_enable_reg[GIE_BIT];
    assign irq_vector = IRQ_VECTOR;

    // ****************************************
    // Watchdog
    // ****************************************

    itw_wdt #(
        .OSC_DIV_P(WDT_OSC_DIV_P)
    ) itw_wdt_i (
        .clk(clk),
        .rst_n(rst_sync_n),
        .watchdog_run(watchdog_run),
        .watchdog_tap_select(watchdog_tap_select),
        .watchdog_clear(watchdog_clear_instr),
        .watchdog_expire(watchdog_expire)
    );

    // Expiry flag outlives the CPU reset it causes; the clear instruction
    // drops it, but a fresh expiry in the same cycle wins
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            watchdog_expired_flag <= 1'b0;
        end else if (watchdog_expire) begin
            watchdog_expired_flag <= 1'b1;
        end else if (watchdog_clear_instr) begin
            watchdog_expired_flag <= 1'b0;
        end
    end

    assign reset_vector = RESET_VECTOR;

    // ****************************************
    // Checks
    // ****************************************

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    sequence s_clear_write;
        wr_tmr && !writedata[TRST_BIT];
    endsequence

    sequence s_clear_done;
        !timer_count_clear_n ##1 (timer_count_clear_n && timer_count_value == 8'h00);
    endsequence

    trst_self_a: assert property (s_clear_write |=> s_clear_done)
        else $error("counter clear did not complete");

    count_hold_a: assert property (!timer_run && timer_count_clear_n |=>
        $stable(timer_count_value) || !$past(timer_count_clear_n))
        else $error("counter moved while stopped");

    count_step_a: assert property (tmr_adv |=>
        timer_count_value == $past(timer_count_value) + 8'h01)
        else $error("counter did not step by one");

    prescale_a: assert property (tmr_adv |-> prescale == 2'h3 && timer_src_en)
        else $error("counter advanced off the prescaler wrap");

    irq_set_a: assert property (tmr_event |=> timer_irq_flag ##1
        (timer_irq_flag || $past(wr_flag)))
        else $error("time-out did not set the flag");

    flag_sticky_a: assert property (timer_irq_flag && !wr_flag |=> timer_irq_flag)
        else $error("flag dropped without a write");

    irq_gate_a: assert property (timer_irq |-> irq_enable_reg[GIE_BIT] &&
        irq_enable_reg[TMR_IE_BIT] && $past(tmr_event || timer_irq_flag))
        else $error("interrupt raised without enables or flag");

    wdt_flag_a: assert property (watchdog_expire |=> watchdog_expired_flag)
        else $error("expiry did not set the status flag");

    count_ro_a: assert property (wr_go && hit_cnt && timer_count_clear_n && !tmr_adv |=>
        $stable(timer_count_value))
        else $error("count register changed by a write");

endmodule
`default_nettype wire

// File: tb/tb_itw_top.sv
// Testbench: register bus, interval timer and watchdog of itw_top
`timescale 1ns/1ns
`default_nettype none
module tb_itw_top;
    import itw_pkg::*;
    // ****************************************
    // Signals and design
    // ****************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] address = 7'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic ext_xtal = 1'b0;
    logic wd_clr = 1'b0;
    logic timer_irq;
    logic [7:0] irq_vector;
    logic watchdog_expire;
    logic [7:0] reset_vector;
    int fails = 0;
    int compares = 0;
    int k;
    // Short watchdog oscillator divider keeps expiry within a few thousand cycles
    itw_top #(.WDT_OSC_DIV_P(4)) itw_top_i (.clk(clk), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .external_crystal_clock(ext_xtal),
        .watchdog_clear_instr(wd_clr), .timer_irq(timer_irq), .irq_vector(irq_vector),
        .watchdog_expire(watchdog_expire), .reset_vector(reset_vector));
    // 100 MHz clock
    always #5 clk = ~clk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Interrupt line settles after the edge that applied the last write
    task automatic irq_chk(input logic e);
        @(negedge clk);
        chk({31'h0, timer_irq}, {31'h0, e});
    endtask
    // One Avalon transfer, held until waitrequest is sampled low; only the watchdog ends a hang
    task automatic bus(input logic [4:0] idx, input logic wr, input logic [7:0] d,
        input logic [3:0] be);
        @(posedge clk);
        address <= {idx, 2'b00};
        writedata <= {24'h000000, d};
        byteenable <= be;
        if (wr) write <= 1'b1;
        else read <= 1'b1;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d, 4'hF);
    endtask
    task automatic rd_chk(input logic [4:0] idx, input logic [7:0] e);
        bus(idx, 1'b0, 8'h00, 4'hF);
        chk(readdata, {24'h000000, e});
    endtask
    // Crystal pulses of four cycles each, then time for the synchroniser
    task automatic xtal(input int n);
        repeat (n) begin
            @(posedge clk);
            ext_xtal <= 1'b1;
            repeat (2) @(posedge clk);
            ext_xtal <= 1'b0;
            @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask
    task automatic wd_pulse();
        @(posedge clk);
        wd_clr <= 1'b1;
        @(posedge clk);
        wd_clr <= 1'b0;
    endtask
    // Cycles until the expiry pulse must fall inside lo..hi, one cycle wide
    task automatic wait_exp(input int lo, input int hi);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (watchdog_expire !== 1'b1 && n < hi);
        chk(n >= lo && n < hi, 1);
        @(posedge clk);
        chk(watchdog_expire, 0);
    endtask
    task automatic quiet(input int n);
        k = 0;
        repeat (n) begin
            @(posedge clk);
            if (watchdog_expire === 1'b1) k++;
        end
    endtask
    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Reset values and unmapped place
        rd_chk(IDX_STATUS, 8'h00);
        rd_chk(IDX_IRQ_FLAG, 8'h00);
        rd_chk(IDX_IRQ_EN, 8'h00);
        rd_chk(IDX_WDT_CTRL, 8'h00);
        rd_chk(IDX_TMR_COUNT, 8'h00);
        rd_chk(IDX_TMR_CTRL, 8'h80);
        rd_chk(IDX_CLK_SEL, 8'h00);
        wr(5'h10, 8'h5A);
        rd_chk(5'h10, 8'h00);
        chk(irq_vector, 32'h04);
        chk(reset_vector, 32'h00);
        $display("test reset done");
        // Access kinds; byteenable zero leaves the register alone
        wr(IDX_CLK_SEL, 8'h2B);
        rd_chk(IDX_CLK_SEL, 8'h2B);
        wr(IDX_CLK_SEL, 8'h20);
        bus(IDX_CLK_SEL, 1'b1, 8'hFF, 4'h0);
        rd_chk(IDX_CLK_SEL, 8'h20);
        wr(IDX_TMR_COUNT, 8'h55);
        rd_chk(IDX_TMR_COUNT, 8'h00);
        $display("test access done");
        // Setup order: source, enables, tap and run, then clear
        wr(IDX_IRQ_EN, 8'h90);
        wr(IDX_TMR_CTRL, 8'h88);
        wr(IDX_TMR_CTRL, 8'h08);
        rd_chk(IDX_TMR_CTRL, 8'h88);
        irq_chk(1'b0);
        xtal(384);
        rd_chk(IDX_TMR_COUNT, 8'h03);
        rd_chk(IDX_IRQ_FLAG, 8'h10);
        irq_chk(1'b1);
        wr(IDX_IRQ_FLAG, 8'h10);
        rd_chk(IDX_IRQ_FLAG, 8'h10);
        wr(IDX_IRQ_EN, 8'h10);
        irq_chk(1'b0);
        wr(IDX_IRQ_EN, 8'h80);
        irq_chk(1'b0);
        wr(IDX_IRQ_EN, 8'h90);
        wr(IDX_IRQ_FLAG, 8'h00);
        rd_chk(IDX_IRQ_FLAG, 8'h00);
        irq_chk(1'b0);
        $display("test timer irq done");
        // Stopped counter holds, then tap one ignores rises of bit zero
        wr(IDX_TMR_CTRL, 8'h80);
        xtal(128);
        rd_chk(IDX_TMR_COUNT, 8'h03);
        wr(IDX_TMR_CTRL, 8'h89);
        xtal(256);
        rd_chk(IDX_TMR_COUNT, 8'h05);
        rd_chk(IDX_IRQ_FLAG, 8'h00);
        xtal(128);
        rd_chk(IDX_IRQ_FLAG, 8'h10);
        $display("test timer tap done");
        // Core path from the plain crystal: 4000 rises give four source ticks, one count
        wr(IDX_CLK_SEL, 8'h01);
        wr(IDX_TMR_CTRL, 8'h09);
        xtal(4000);
        rd_chk(IDX_TMR_COUNT, 8'h01);
        // Halved crystal: only two more ticks, so the count must not move
        wr(IDX_CLK_SEL, 8'h09);
        xtal(4000);
        rd_chk(IDX_TMR_COUNT, 8'h01);
        $display("test core path done");
        // Watchdog: tap code 7 is bit 0, 256 rises of eight cycles each
        wr(IDX_WDT_CTRL, 8'h87);
        wd_pulse();
        wait_exp(1950, 2200);
        rd_chk(IDX_STATUS, 8'h08);
        wd_pulse();
        rd_chk(IDX_STATUS, 8'h00);
        // Periodic clearing keeps the watchdog quiet
        repeat (4) begin
            quiet(1200);
            chk(k, 0);
            wd_pulse();
        end
        // Tap code 6 is bit 1: expiry takes twice as long
        wr(IDX_WDT_CTRL, 8'h86);
        wd_pulse();
        wait_exp(3950, 4300);
        wr(IDX_WDT_CTRL, 8'h06);
        wd_pulse();
        quiet(5000);
        chk(k, 0);
        $display("test watchdog done");
        complete_run();
    end
    // Watchdog on the whole run: 80000 cycles against the roughly 52000 needed
    initial begin
        #800000;
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
